// [dv/backlight_ctrl_regs_test.sv]
// Purpose: Self-checking bench for the backlight register bank
// Assumes: APB slave paces itself with PREADY; one clock, async active-low reset
// Notes: A monitor checks every completed transfer against a queue of expectations
`timescale 1ns/100ps
`include "bcr_defs.svh"

module backlight_ctrl_regs_test;
    import bcr_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [11:0] adc_result = 12'h000;
    logic adc_valid = 1'b0;
    logic cal_done = 1'b0;
    logic [4:0] byte_idx = 5'h00;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready, pslverr, irq, erase_go, write_go, cal_idle;
    logic [1:0] page_sel;
    logic [4:0] boost;
    wire [5:0] ctrl_o;
    bcr_byte_t cal_byte;
    wire bcr_byte_t gain [3];
    bcr_byte_t pbuf [32];
    logic [33:0] expq [$];
    logic [33:0] e;
    int fail_count = 0;
    int n_tests = 0;
    int n_erase = 0;
    int n_write = 0;

    bcr_regs bcr_regs_i (.SYS_CLK(sys_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .ADC_RESULT(adc_result),
        .ADC_VALID(adc_valid), .CALMEM_DONE(cal_done), .CALMEM_BYTE_IDX(byte_idx),
        .CALMEM_BYTE(cal_byte), .CALMEM_ERASE_GO(erase_go), .CALMEM_WRITE_GO(write_go),
        .CALMEM_IDLE(cal_idle), .CALMEM_PAGE_SEL(page_sel), .BOOST_VCODE(boost),
        .TEMP_SOURCE_SEL(ctrl_o[5]), .SENSOR_SEL(ctrl_o[4]), .AUTOLOAD_EN(ctrl_o[3]),
        .VOUT_ADAPTIVE(ctrl_o[2]), .BOOST_EN(ctrl_o[1]), .ACTIVE_MODE(ctrl_o[0]),
        .RED_GAIN(gain[0]), .GREEN_GAIN(gain[1]), .BLUE_GAIN(gain[2]));

    always #12.5 sys_clk = ~sys_clk;

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    // Upper write bits are random: only the low byte may have any effect
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic err, input logic [7:0] rd);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'($urandom), wd};
        expq.push_back({~wr, err, 24'h000000, rd});
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            chk(1'b0, 1'b1, "no ready");
            test_done();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00, 1'b0, exp);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 1'b0, 8'h00);
    endtask

    task automatic pulse_adc(input logic [11:0] a);
        @(posedge sys_clk);
        adc_result <= a;
        adc_valid <= 1'b1;
        @(posedge sys_clk);
        adc_valid <= 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic pulse_done();
        @(posedge sys_clk);
        cal_done <= 1'b1;
        @(posedge sys_clk);
        cal_done <= 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    always @(posedge sys_clk) begin
        if (erase_go === 1'b1)
            n_erase++;
        if (write_go === 1'b1)
            n_write++;
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            chk(pslverr, e[32], "slave error");
            if (e[33])
                chk(prdata, e[31:0], "read data");
        end
    end

    initial begin
        #(25 * 8000);
        chk(1'b0, 1'b1, "watchdog expired");
        test_done();
    end

    initial begin
        logic [7:0] ridx [10];
        logic [7:0] rrst [10];
        logic [4:0] v;
        logic [7:0] d;
        logic [11:0] a;
        int ne;
        int nw;
        ridx = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F};
        rrst = '{8'h00, 8'h04, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h00, 8'h00};
        void'($urandom(32'h4555));
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(negedge sys_clk);
        chk({boost, ctrl_o, cal_idle, page_sel, gain[0], gain[1], gain[2]},
            {5'h05, 6'h04, 1'b1, 2'h0, 24'h808080}, "reset outputs");
        for (int i = 0; i < 10; i++)
            rd(ridx[i], rrst[i]);
        for (int c = 0; c < 32; c++) begin
            v = c[4:0];
            wr(`BCR_IDX_BOOST, {3'($urandom), v});
            @(negedge sys_clk);
            chk(boost, (v < 5'h05) ? 5'h05 : ((v > 5'h14) ? 5'h14 : v), "boost");
            rd(`BCR_IDX_BOOST, {3'h0, v});
        end
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            wr(`BCR_IDX_CTRL, d);
            @(negedge sys_clk);
            chk(ctrl_o, d[5:0], "control bits");
            rd(`BCR_IDX_CTRL, {2'h0, d[5:0]});
        end
        for (int g = 0; g < 3; g++) begin
            d = 8'($urandom);
            wr(`BCR_IDX_GAIN_R + 8'(g), d);
            @(negedge sys_clk);
            chk(gain[g], d, "gain output");
            rd(`BCR_IDX_GAIN_R + 8'(g), d);
        end
        // Low byte strobe off: the write must not land
        pstrb <= 4'h0;
        wr(`BCR_IDX_GAIN_B, ~d);
        pstrb <= 4'hF;
        @(negedge sys_clk);
        chk(gain[2], d, "strobe-gated write dropped");
        rd(`BCR_IDX_GAIN_B, d);
        wr(`BCR_IDX_IRQ_MASK, 8'h03);
        rd(`BCR_IDX_IRQ_MASK, 8'h03);
        a = 12'($urandom);
        pulse_adc(a);
        chk(irq, 1'b1, "interrupt raised");
        wr(`BCR_IDX_ADC_HI, 8'hFF);
        rd(`BCR_IDX_ADC_HI, {4'h0, a[11:8]});
        rd(`BCR_IDX_ADC_LO, a[7:0]);
        rd(`BCR_IDX_IRQ_ST, 8'h01);
        @(negedge sys_clk);
        chk(irq, 1'b0, "interrupt cleared");
        rd(`BCR_IDX_IRQ_ST, 8'h00);
        wr(`BCR_IDX_IRQ_MASK, 8'h00);
        pulse_adc(12'hFFF);
        chk(irq, 1'b0, "interrupt masked");
        rd(`BCR_IDX_IRQ_ST, 8'h01);
        wr(`BCR_IDX_IRQ_MASK, 8'h03);
        // Indices just outside the window edges and holes of the map must refuse
        apb(1'b0, 8'h07, 8'h00, 1'b1, 8'h00);
        apb(1'b0, 8'h3F, 8'h00, 1'b1, 8'h00);
        apb(1'b0, 8'h60, 8'h00, 1'b1, 8'h00);
        apb(1'b1, 8'h10, 8'h55, 1'b1, 8'h00);
        for (int i = 0; i < 32; i++) begin
            pbuf[i] = 8'($urandom);
            wr(8'h40 + 8'(i), pbuf[i]);
        end
        for (int i = 0; i < 32; i++)
            rd(8'h40 + 8'(i), pbuf[i]);
        @(posedge sys_clk);
        byte_idx <= 5'h1F;
        repeat (2) @(negedge sys_clk);
        chk(cal_byte, pbuf[31], "engine byte");
        wr(`BCR_IDX_CALCTL, 8'h02);
        @(negedge sys_clk);
        chk(page_sel, 2'h2, "page select");
        rd(`BCR_IDX_CALCTL, 8'h82);
        ne = n_erase;
        nw = n_write;
        wr(`BCR_IDX_CALCTL, 8'h41);
        repeat (3) @(negedge sys_clk);
        chk({n_erase - ne, cal_idle}, {32'd1, 1'b0}, "erase start");
        rd(`BCR_IDX_CALCTL, 8'h01);
        wr(`BCR_IDX_CALCTL, 8'h23);
        rd(`BCR_IDX_CALCTL, 8'h01);
        pulse_done();
        chk({n_write - nw, cal_idle}, {32'd0, 1'b1}, "busy write ignored");
        rd(`BCR_IDX_IRQ_ST, 8'h02);
        wr(`BCR_IDX_CALCTL, 8'h60);
        pulse_done();
        wr(`BCR_IDX_CALCTL, 8'h20);
        repeat (3) @(negedge sys_clk);
        chk({n_erase - ne, n_write - nw, cal_idle}, {32'd2, 32'd1, 1'b0}, "starts");
        pulse_done();
        test_done();
    end
endmodule // backlight_ctrl_regs_test

// [verilog/bcr_defs.svh]
// Purpose: Register indices, field positions, reset values for the backlight register bank
// Assumes: Byte address on APB is four times the register index
// Notes: Definitions only
`ifndef BCR_DEFS_SVH
`define BCR_DEFS_SVH

`define BCR_IDX_BOOST     8'h05
`define BCR_IDX_CTRL      8'h06
`define BCR_IDX_ADC_HI    8'h08
`define BCR_IDX_ADC_LO    8'h09
`define BCR_IDX_GAIN_R    8'h0A
`define BCR_IDX_GAIN_G    8'h0B
`define BCR_IDX_GAIN_B    8'h0C
`define BCR_IDX_CALCTL    8'h0D
`define BCR_IDX_IRQ_ST    8'h0E
`define BCR_IDX_IRQ_MASK  8'h0F
`define BCR_IDX_WIN_LO    8'h40
`define BCR_IDX_WIN_HI    8'h5F

`define BCR_CTRL_TEMPSRC  5
`define BCR_CTRL_SENSOR   4
`define BCR_CTRL_AUTOLOAD 3
`define BCR_CTRL_VADAPT   2
`define BCR_CTRL_BOOSTEN  1
`define BCR_CTRL_ACTIVE   0

`define BCR_CAL_READY     7
`define BCR_CAL_ERASE     6
`define BCR_CAL_WRITE     5

`define BCR_IRQ_ADC       0
`define BCR_IRQ_CALDONE   1

`define BCR_RST_BOOST     5'h00
`define BCR_RST_CTRL      6'h04
`define BCR_RST_GAIN      8'h80
`define BCR_RST_PAGE      2'h0
`define BCR_RST_MASK      2'h0

`define BCR_VCODE_MIN     5'h05
`define BCR_VCODE_MAX     5'h14

`endif

// [verilog/bcr_pkg.sv]
// Purpose: Types for the backlight register bank
// Assumes: Constants come from bcr_defs.svh
// Notes: Whole module state is one packed struct
package bcr_pkg;
    typedef logic [7:0] bcr_byte_t;

    typedef struct packed {
        logic [4:0] vcode_raw;
        logic [4:0] vcode_out;
        logic [5:0] ctrl;
        logic [11:0] adc;
        bcr_byte_t gain_r;
        bcr_byte_t gain_g;
        bcr_byte_t gain_b;
        logic ready;
        logic [1:0] page;
        logic erase_go;
        logic write_go;
        bcr_byte_t [31:0] page_buf;
        bcr_byte_t cal_byte;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } bcr_state_s;
endpackage

// [verilog/bcr_regs.sv]
// Purpose: APB register bank of an RGB backlight driver
// Assumes: ADC and calibration engine run on SYS_CLK; APB on SYS_CLK
// Notes: No wait states per transfer; PREADY and PRDATA are registered
`timescale 1ns/100ps
`include "bcr_defs.svh"

module bcr_regs (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [9:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire logic [11:0] ADC_RESULT,
    input wire logic ADC_VALID,
    input wire logic CALMEM_DONE,
    input wire logic [4:0] CALMEM_BYTE_IDX,
    output bcr_pkg::bcr_byte_t CALMEM_BYTE,
    output logic CALMEM_ERASE_GO,
    output logic CALMEM_WRITE_GO,
    output logic CALMEM_IDLE,
    output logic [1:0] CALMEM_PAGE_SEL,
    output logic [4:0] BOOST_VCODE,
    output logic TEMP_SOURCE_SEL,
    output logic SENSOR_SEL,
    output logic AUTOLOAD_EN,
    output logic VOUT_ADAPTIVE,
    output logic BOOST_EN,
    output logic ACTIVE_MODE,
    output bcr_pkg::bcr_byte_t RED_GAIN,
    output bcr_pkg::bcr_byte_t GREEN_GAIN,
    output bcr_pkg::bcr_byte_t BLUE_GAIN
);
    import bcr_pkg::*;

    bcr_state_s s_q;
    bcr_state_s s_d;
    logic [7:0] idx;
    logic setup_ph;
    logic acc_wr;
    logic acc_rd;
    logic in_win;
    logic mapped;
    logic [1:0] ev;
    logic [31:0] rd_word;

    assign idx = PADDR[9:2];
    assign setup_ph = PSEL && !PENABLE;
    assign acc_wr = PSEL && PENABLE && s_q.pready && PWRITE && PSTRB[0];
    assign acc_rd = PSEL && PENABLE && s_q.pready && !PWRITE;
    assign in_win = (idx >= `BCR_IDX_WIN_LO) && (idx <= `BCR_IDX_WIN_HI);
    assign mapped = in_win || (idx == `BCR_IDX_BOOST) || (idx == `BCR_IDX_CTRL)
        || ((idx >= `BCR_IDX_ADC_HI) && (idx <= `BCR_IDX_IRQ_MASK));

    always_comb begin
        ev = 2'h0;
        ev[`BCR_IRQ_ADC] = ADC_VALID;
        ev[`BCR_IRQ_CALDONE] = CALMEM_DONE && !s_q.ready;
    end

    // Read mux; status read shows events of this very cycle so none is lost
    always_comb begin
        rd_word = 32'h0000_0000;
        if (in_win) begin
            rd_word[7:0] = s_q.page_buf[idx[4:0]];
        end else begin
            unique case (idx)
                `BCR_IDX_BOOST: rd_word[4:0] = s_q.vcode_raw;
                `BCR_IDX_CTRL: rd_word[5:0] = s_q.ctrl;
                `BCR_IDX_ADC_HI: rd_word[3:0] = s_q.adc[11:8];
                `BCR_IDX_ADC_LO: rd_word[7:0] = s_q.adc[7:0];
                `BCR_IDX_GAIN_R: rd_word[7:0] = s_q.gain_r;
                `BCR_IDX_GAIN_G: rd_word[7:0] = s_q.gain_g;
                `BCR_IDX_GAIN_B: rd_word[7:0] = s_q.gain_b;
                `BCR_IDX_CALCTL: begin
                    rd_word[`BCR_CAL_READY] = s_q.ready;
                    rd_word[1:0] = s_q.page;
                end
                `BCR_IDX_IRQ_ST: rd_word[1:0] = s_q.irq_st | ev;
                `BCR_IDX_IRQ_MASK: rd_word[1:0] = s_q.irq_mask;
                default: rd_word = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.erase_go = 1'b0;
        s_d.write_go = 1'b0;
        s_d.pready = setup_ph;
        s_d.pslverr = setup_ph && !mapped;
        if (setup_ph) begin
            s_d.prdata = rd_word;
        end
        if (ADC_VALID) begin
            s_d.adc = ADC_RESULT;
        end
        if (CALMEM_DONE) begin
            s_d.ready = 1'b1;
        end
        // Reported bits clear on read; fresh events win over the clear
        if (acc_rd && (idx == `BCR_IDX_IRQ_ST)) begin
            s_d.irq_st = s_q.irq_st & ~s_q.prdata[1:0];
        end
        s_d.irq_st = s_d.irq_st | ev;
        if (acc_wr) begin
            if (in_win) begin
                s_d.page_buf[idx[4:0]] = PWDATA[7:0];
            end else begin
                unique case (idx)
                    `BCR_IDX_BOOST: s_d.vcode_raw = PWDATA[4:0];
                    `BCR_IDX_CTRL: s_d.ctrl = PWDATA[5:0];
                    `BCR_IDX_GAIN_R: s_d.gain_r = PWDATA[7:0];
                    `BCR_IDX_GAIN_G: s_d.gain_g = PWDATA[7:0];
                    `BCR_IDX_GAIN_B: s_d.gain_b = PWDATA[7:0];
                    `BCR_IDX_CALCTL: begin
                        // Page held while busy so the engine sees a stable page
                        if (s_q.ready) begin
                            s_d.page = PWDATA[1:0];
                            if (PWDATA[`BCR_CAL_ERASE]) begin
                                s_d.erase_go = 1'b1;
                                s_d.ready = 1'b0;
                            end else if (PWDATA[`BCR_CAL_WRITE]) begin
                                s_d.write_go = 1'b1;
                                s_d.ready = 1'b0;
                            end
                        end
                    end
                    `BCR_IDX_IRQ_MASK: s_d.irq_mask = PWDATA[1:0];
                    default: s_d.ctrl = s_q.ctrl;
                endcase
            end
        end
        // Out-of-range codes clamp to the nearest valid target
        if (s_d.vcode_raw < `BCR_VCODE_MIN) begin
            s_d.vcode_out = `BCR_VCODE_MIN;
        end else if (s_d.vcode_raw > `BCR_VCODE_MAX) begin
            s_d.vcode_out = `BCR_VCODE_MAX;
        end else begin
            s_d.vcode_out = s_d.vcode_raw;
        end
        s_d.cal_byte = s_d.page_buf[CALMEM_BYTE_IDX];
        s_d.irq = |(s_d.irq_st & s_d.irq_mask);
    end

    always_ff @(posedge SYS_CLK or negedge RESETN) begin
        if (!RESETN) begin
            s_q <= '0;
            s_q.vcode_raw <= `BCR_RST_BOOST;
            s_q.vcode_out <= `BCR_VCODE_MIN;
            s_q.ctrl <= `BCR_RST_CTRL;
            s_q.gain_r <= `BCR_RST_GAIN;
            s_q.gain_g <= `BCR_RST_GAIN;
            s_q.gain_b <= `BCR_RST_GAIN;
            s_q.ready <= 1'b1;
            s_q.page <= `BCR_RST_PAGE;
            s_q.irq_mask <= `BCR_RST_MASK;
        end else begin
            s_q <= s_d;
        end
    end

    assign PRDATA = s_q.prdata;
    assign PREADY = s_q.pready;
    assign PSLVERR = s_q.pslverr;
    assign IRQ = s_q.irq;
    assign CALMEM_BYTE = s_q.cal_byte;
    assign CALMEM_ERASE_GO = s_q.erase_go;
    assign CALMEM_WRITE_GO = s_q.write_go;
    assign CALMEM_IDLE = s_q.ready;
    assign CALMEM_PAGE_SEL = s_q.page;
    assign BOOST_VCODE = s_q.vcode_out;
    assign TEMP_SOURCE_SEL = s_q.ctrl[`BCR_CTRL_TEMPSRC];
    assign SENSOR_SEL = s_q.ctrl[`BCR_CTRL_SENSOR];
    assign AUTOLOAD_EN = s_q.ctrl[`BCR_CTRL_AUTOLOAD];
    assign VOUT_ADAPTIVE = s_q.ctrl[`BCR_CTRL_VADAPT];
    assign BOOST_EN = s_q.ctrl[`BCR_CTRL_BOOSTEN];
    assign ACTIVE_MODE = s_q.ctrl[`BCR_CTRL_ACTIVE];
    assign RED_GAIN = s_q.gain_r;
    assign GREEN_GAIN = s_q.gain_g;
    assign BLUE_GAIN = s_q.gain_b;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESETN);

    property p_vcode_range;
        (BOOST_VCODE >= `BCR_VCODE_MIN) && (BOOST_VCODE <= `BCR_VCODE_MAX);
    endproperty
    a_vcode_range: assert property (p_vcode_range)
        else $error("boost code outside 5 V to 20 V");

    property p_ctrl_write;
        acc_wr && (idx == `BCR_IDX_CTRL) |=>
            {TEMP_SOURCE_SEL, SENSOR_SEL, AUTOLOAD_EN, VOUT_ADAPTIVE, BOOST_EN, ACTIVE_MODE}
            == $past(PWDATA[5:0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write)
        else $error("control outputs differ from written value");

    property p_adc_hi;
        setup_ph && (idx == `BCR_IDX_ADC_HI) |=>
            (PRDATA[31:4] == 28'h0000000) && (PRDATA[3:0] == $past(s_q.adc[11:8]));
    endproperty
    a_adc_hi: assert property (p_adc_hi)
        else $error("high result byte read wrong");

    property p_adc_lo;
        setup_ph && (idx == `BCR_IDX_ADC_LO) |=>
            (PRDATA == {24'h000000, $past(s_q.adc[7:0])});
    endproperty
    a_adc_lo: assert property (p_adc_lo)
        else $error("low result byte read wrong");

    property p_gain_write;
        acc_wr && (idx == `BCR_IDX_GAIN_G) |=> GREEN_GAIN == $past(PWDATA[7:0])
            ##1 GREEN_GAIN == $past(GREEN_GAIN);
    endproperty
    a_gain_write: assert property (p_gain_write)
        else $error("gain register did not take write");

    property p_erase_start;
        acc_wr && (idx == `BCR_IDX_CALCTL) && CALMEM_IDLE && PWDATA[`BCR_CAL_ERASE] |=>
            CALMEM_ERASE_GO && !CALMEM_IDLE ##1 !CALMEM_ERASE_GO;
    endproperty
    a_erase_start: assert property (p_erase_start)
        else $error("erase start not a single pulse");

    property p_write_start;
        acc_wr && (idx == `BCR_IDX_CALCTL) && CALMEM_IDLE && PWDATA[`BCR_CAL_WRITE]
            && !PWDATA[`BCR_CAL_ERASE] |=> CALMEM_WRITE_GO && !CALMEM_IDLE;
    endproperty
    a_write_start: assert property (p_write_start)
        else $error("program start not issued");

    property p_busy_ignore;
        !CALMEM_IDLE |=> !CALMEM_ERASE_GO && !CALMEM_WRITE_GO
            && (CALMEM_PAGE_SEL == $past(CALMEM_PAGE_SEL));
    endproperty
    a_busy_ignore: assert property (p_busy_ignore)
        else $error("start accepted while busy");

    property p_window_read;
        setup_ph && in_win |=> PRDATA[7:0] == $past(s_q.page_buf[idx[4:0]]);
    endproperty
    a_window_read: assert property (p_window_read)
        else $error("page window read wrong");

    property p_unmapped;
        setup_ph && !mapped |=> PSLVERR && PREADY && (PRDATA == 32'h0000_0000);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    property p_page_write;
        acc_wr && (idx == `BCR_IDX_CALCTL) && CALMEM_IDLE |=>
            CALMEM_PAGE_SEL == $past(PWDATA[1:0]);
    endproperty
    a_page_write: assert property (p_page_write)
        else $error("page select not updated");

    property p_ready_back;
        !CALMEM_IDLE && CALMEM_DONE |=> CALMEM_IDLE;
    endproperty
    a_ready_back: assert property (p_ready_back)
        else $error("ready flag did not return");

    property p_vcode_pass;
        acc_wr && (idx == `BCR_IDX_BOOST) && (PWDATA[4:0] >= `BCR_VCODE_MIN)
            && (PWDATA[4:0] <= `BCR_VCODE_MAX) |=> BOOST_VCODE == $past(PWDATA[4:0]);
    endproperty
    a_vcode_pass: assert property (p_vcode_pass)
        else $error("in-range boost code not passed through");

    // Codes outside the table pin to the nearest end, never wrap
    property p_vcode_clamp;
        acc_wr && (idx == `BCR_IDX_BOOST) && (PWDATA[4:0] > `BCR_VCODE_MAX)
            |=> BOOST_VCODE == `BCR_VCODE_MAX;
    endproperty
    a_vcode_clamp: assert property (p_vcode_clamp)
        else $error("high boost code not clamped");

    property p_vcode_floor;
        acc_wr && (idx == `BCR_IDX_BOOST) && (PWDATA[4:0] < `BCR_VCODE_MIN)
            |=> BOOST_VCODE == `BCR_VCODE_MIN;
    endproperty
    a_vcode_floor: assert property (p_vcode_floor)
        else $error("low boost code not clamped");

    property p_ctrl_hold;
        !(acc_wr && (idx == `BCR_IDX_CTRL)) |=>
            $stable({TEMP_SOURCE_SEL, SENSOR_SEL, AUTOLOAD_EN})
            && $stable({VOUT_ADAPTIVE, BOOST_EN, ACTIVE_MODE});
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold)
        else $error("control bits changed without a write");

    property p_adc_capture;
        ADC_VALID |=> s_q.adc == $past(ADC_RESULT);
    endproperty
    a_adc_capture: assert property (p_adc_capture)
        else $error("conversion word not captured");

    property p_adc_ro;
        acc_wr && ((idx == `BCR_IDX_ADC_HI) || (idx == `BCR_IDX_ADC_LO)) && !ADC_VALID
            |=> $stable(s_q.adc);
    endproperty
    a_adc_ro: assert property (p_adc_ro)
        else $error("write reached a read-only result byte");

    property p_red_write;
        acc_wr && (idx == `BCR_IDX_GAIN_R) |=> RED_GAIN == $past(PWDATA[7:0]);
    endproperty
    a_red_write: assert property (p_red_write)
        else $error("red gain did not take write");

    property p_blue_write;
        acc_wr && (idx == `BCR_IDX_GAIN_B) |=> BLUE_GAIN == $past(PWDATA[7:0]);
    endproperty
    a_blue_write: assert property (p_blue_write)
        else $error("blue gain did not take write");

    // Idle may only drop through an accepted start
    property p_idle_hold;
        CALMEM_IDLE && !(acc_wr && (idx == `BCR_IDX_CALCTL)) |=> CALMEM_IDLE;
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("ready flag dropped without a start");

    property p_erase_wins;
        acc_wr && (idx == `BCR_IDX_CALCTL) && CALMEM_IDLE && PWDATA[`BCR_CAL_ERASE]
            && PWDATA[`BCR_CAL_WRITE] |=> CALMEM_ERASE_GO && !CALMEM_WRITE_GO;
    endproperty
    a_erase_wins: assert property (p_erase_wins)
        else $error("both start bits did not resolve to erase");

    property p_go_single;
        (CALMEM_ERASE_GO || CALMEM_WRITE_GO) |=> !CALMEM_ERASE_GO && !CALMEM_WRITE_GO;
    endproperty
    a_go_single: assert property (p_go_single)
        else $error("start pulse longer than one cycle");

    property p_upper_zero;
        PREADY |-> PRDATA[31:8] == 24'h000000;
    endproperty
    a_upper_zero: assert property (p_upper_zero)
        else $error("unused read bits not zero");

    property p_window_write;
        acc_wr && in_win |=> s_q.page_buf[$past(idx[4:0])] == $past(PWDATA[7:0]);
    endproperty
    a_window_write: assert property (p_window_write)
        else $error("page window write lost");

    c_erase: cover property (CALMEM_ERASE_GO ##[1:50] CALMEM_IDLE);
    c_irq: cover property (IRQ ##[1:20] !IRQ);
    c_clamp: cover property (acc_wr && (idx == `BCR_IDX_BOOST) && (PWDATA[4:0] > 5'h14));
    c_busy_write: cover property (!CALMEM_IDLE && acc_wr && (idx == `BCR_IDX_CALCTL));
    c_status_clear: cover property (acc_rd && (idx == `BCR_IDX_IRQ_ST) && (|s_q.irq_st));
endmodule // bcr_regs
